// ===== logic/fsr_pkg.sv
// Package: opcodes, timing and types for the flash suspend/resume control
package fsr_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Always-permitted commands
   localparam logic [7:0] OPC_RDSR_A = 8'h05, OPC_RDSR_B = 8'h35, OPC_RDSR_C = 8'h15;
   localparam logic [7:0] OPC_RDSR_I = 8'h65, OPC_ACT_INT = 8'h25, OPC_TERM = 8'hF0;
   localparam logic [7:0] OPC_RST_EN = 8'h66, OPC_RST = 8'h99, OPC_DPD_EXIT = 8'hAB;
   localparam logic [7:0] OPC_ID_A = 8'h9F, OPC_ID_B = 8'h90, OPC_ID_C = 8'h94;
   // Suspend and resume
   localparam logic [7:0] OPC_HALT_A = 8'h75, OPC_HALT_B = 8'hB0;
   localparam logic [7:0] OPC_RES_A = 8'h7A, OPC_RES_B = 8'hD0;
   // Permitted while suspended
   localparam logic [7:0] OPC_RD_A = 8'h03, OPC_RD_B = 8'h0B, OPC_RD_C = 8'h3B;
   localparam logic [7:0] OPC_RD_D = 8'h6B, OPC_RD_E = 8'hEB, OPC_RD_F = 8'hE7;
   localparam logic [7:0] OPC_BUF_RD = 8'hD4, OPC_WREN = 8'h06, OPC_WRDI = 8'h04;
   localparam logic [7:0] OPC_VWREN = 8'h50, OPC_LKST_A = 8'h3C, OPC_LKST_B = 8'h3D;
   localparam logic [7:0] OPC_OTP_RD = 8'h4B, OPC_SFDP = 8'h5A, OPC_WRAP = 8'h77;
   localparam logic [7:0] OPC_BATT = 8'hEF;
   // Permitted only during erase suspension, other block for programs
   localparam logic [7:0] OPC_BUF_WR = 8'h84, OPC_PP_A = 8'h02, OPC_PP_B = 8'hA2;
   localparam logic [7:0] OPC_PP_C = 8'h32, OPC_BUF_PP = 8'h88, OPC_SEQ_A = 8'hAD;
   localparam logic [7:0] OPC_SEQ_B = 8'hAF;
   // Named refusals
   localparam logic [7:0] OPC_WRSR_I = 8'h71, OPC_SR_LOCK = 8'h6F, OPC_DPD = 8'hB9;
   localparam logic [7:0] OPC_UDPD = 8'h79;
   ////////////////////////////////////////////////////////////////////////////
   // Timing: latencies as longest times, rounded down
   localparam int CLK_PERIOD_NS   = 50;
   localparam int HALT_LAT_NS     = 20000;
   localparam int CONT_LAT_NS     = 20000;
   localparam int HALT_LAT_CYC    = (HALT_LAT_NS / CLK_PERIOD_NS < 1) ? 1
                                    : HALT_LAT_NS / CLK_PERIOD_NS;
   localparam int CONT_LAT_CYC    = (CONT_LAT_NS / CLK_PERIOD_NS < 1) ? 1
                                    : CONT_LAT_NS / CLK_PERIOD_NS;
   localparam int TMR_W           = 12;
   localparam int BLK_W           = 4;
   localparam logic [BLK_W-1:0] BLK_RST = 4'h0;
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {KIND_NONE, KIND_PROG, KIND_ERASE, KIND_FIXED} fsr_kind_t;
   typedef enum logic [1:0] {PEND_NONE, PEND_HALT, PEND_RES} fsr_pend_t;
endpackage : fsr_pkg

// ===== logic/fsr_tmr_if.sv
// Interface between the control core and its latency timer
`timescale 1ns/1ps
interface fsr_tmr_if;
   import fsr_pkg::*;
   logic             start;
   logic [TMR_W-1:0] count;
   logic             busy;
   modport ctrl (output start, output count, input busy);
   modport tmr  (input start, input count, output busy);
endinterface : fsr_tmr_if

// ===== logic/fsr_latency_timer.sv
// Down-counting latency window timer
`timescale 1ns/1ps
module fsr_latency_timer
   import fsr_pkg::*;
(
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   // Control side
   fsr_tmr_if.tmr    tmr
);
   typedef struct packed {
      logic [TMR_W-1:0] cnt;
   } fsr_tmr_st_t;

   fsr_tmr_st_t st_r;
   fsr_tmr_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (tmr.start)
      begin
         st_nxt.cnt = tmr.count;
      end
      else if (st_r.cnt != '0)
      begin
         st_nxt.cnt = st_r.cnt - 12'h001;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign tmr.busy = (st_r.cnt != '0);
endmodule : fsr_latency_timer

// ===== logic/fsr_ctrl.sv
// Command admission and program/erase suspend-resume control
//
// Function
// - While busy, only status, interrupt, terminate, reset, ID, wake and suspend commands pass.
// - Program suspended: SFDP, wrap, battery pass; status write, lock, power-downs refused.
// - Erase suspended: SFDP, wrap, battery pass; status lock and power-down refused.
// - During erase suspension, programs only target another 64 kB block.
// - Suspend at chip select rise: halt, set paused and kind flag, clear busy.
// - Suspend ignored during status writes, lock, OTP, chip erase, RMW, sequential.
// - Program may run in erase suspension; erase refused in program suspension.
// - Suspend and resume ignore the write enable latch.
// - Suspend only with complete opcode and byte-aligned chip select rise.
// - Reads of the suspended area give undefined data.
// - Two resume opcodes, identical behaviour.
// - Resume accepted only with a suspended flag set and busy clear.
// - Resume clears the kind flag, paused when both clear, and sets busy.
// - After resume chip select rise, restart the operation within the latency.
// - Resume only with complete opcode and byte-aligned chip select rise.
// - Suspend ignored while a resume takes effect.
// - With both suspended, first resume restarts the program, next the erase.
// - Two suspend opcodes, executed when chip select rises.
// - Refused commands are dropped without action or write latch change.
`timescale 1ns/1ps
module fsr_ctrl
   import fsr_pkg::*;
(
   // Clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_reset,
   // Command decoder: opcode after its eighth clock
   input  wire logic             i_cmd_valid,
   input  wire logic [7:0]       i_cmd_opcode,
   input  wire logic [BLK_W-1:0] i_cmd_block,
   output logic                  o_cmd_accept,
   output logic                  o_cmd_drop,
   output logic                  o_read_undefined,
   // Chip select deassertion event
   input  wire logic             i_cs_rise,
   input  wire logic             i_cs_aligned,
   // Array sequencer
   input  wire logic             i_op_start,
   input  wire fsr_kind_t        i_op_kind,
   input  wire logic [BLK_W-1:0] i_op_block,
   input  wire logic             i_op_done,
   output logic                  o_suspend_req,
   output logic                  o_resume_req,
   output logic                  o_resume_is_erase,
   output logic                  o_latency_busy,
   // Status flags
   output logic                  o_ready_busy_flag,
   output logic                  o_paused_op_flag,
   output logic                  o_program_suspended_flag,
   output logic                  o_erase_suspended_flag
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic             busy;
      logic             paused;
      logic             prg_held;
      logic             ers_held;
      fsr_kind_t        run;
      logic [BLK_W-1:0] run_blk;
      logic [BLK_W-1:0] prg_blk;
      logic [BLK_W-1:0] ers_blk;
      fsr_pend_t        pend;
      logic             halt_req;
      logic             res_req;
      logic             res_erase;
   } fsr_st_t;

   fsr_st_t st_r;
   fsr_st_t st_nxt;

   fsr_tmr_if tmr_if ();

   fsr_latency_timer u_timer (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .tmr        (tmr_if.tmr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Opcode classes
   function automatic logic is_halt(input logic [7:0] op);
      is_halt = (op == OPC_HALT_A) || (op == OPC_HALT_B);
   endfunction : is_halt

   function automatic logic is_res(input logic [7:0] op);
      is_res = (op == OPC_RES_A) || (op == OPC_RES_B);
   endfunction : is_res

   function automatic logic is_always(input logic [7:0] op);
      case (op)
         OPC_RDSR_A, OPC_RDSR_B, OPC_RDSR_C, OPC_RDSR_I, OPC_ACT_INT, OPC_TERM,
         OPC_RST_EN, OPC_RST, OPC_DPD_EXIT, OPC_ID_A, OPC_ID_B, OPC_ID_C:
            is_always = 1'b1;
         default:
            is_always = 1'b0;
      endcase
   endfunction : is_always

   function automatic logic is_read(input logic [7:0] op);
      case (op)
         OPC_RD_A, OPC_RD_B, OPC_RD_C, OPC_RD_D, OPC_RD_E, OPC_RD_F:
            is_read = 1'b1;
         default:
            is_read = 1'b0;
      endcase
   endfunction : is_read

   function automatic logic is_held_ok(input logic [7:0] op);
      case (op)
         OPC_BUF_RD, OPC_WREN, OPC_WRDI, OPC_VWREN, OPC_LKST_A, OPC_LKST_B,
         OPC_OTP_RD, OPC_SFDP, OPC_WRAP, OPC_BATT:
            is_held_ok = 1'b1;
         default:
            is_held_ok = is_read(op);
      endcase
   endfunction : is_held_ok

   function automatic logic is_prog(input logic [7:0] op);
      case (op)
         OPC_PP_A, OPC_PP_B, OPC_PP_C, OPC_BUF_PP, OPC_SEQ_A, OPC_SEQ_B:
            is_prog = 1'b1;
         default:
            is_prog = 1'b0;
      endcase
   endfunction : is_prog

   ////////////////////////////////////////////////////////////////////////////
   // Admission
   logic can_suspend;
   logic can_resume;
   logic allowed;

   // Write latch plays no part in either decision
   assign can_suspend = st_r.busy && (st_r.run == KIND_PROG || st_r.run == KIND_ERASE)
                        && !tmr_if.busy;
   assign can_resume  = (st_r.prg_held || st_r.ers_held) && !st_r.busy
                        && !tmr_if.busy;

   always_comb
   begin
      allowed = 1'b0;
      if (is_always(i_cmd_opcode))
      begin
         allowed = 1'b1;
      end
      else if (st_r.busy)
      begin
         allowed = is_halt(i_cmd_opcode) && can_suspend;
      end
      else if (st_r.prg_held)
      begin
         allowed = is_held_ok(i_cmd_opcode)
                   || (is_res(i_cmd_opcode) && can_resume);
      end
      else if (st_r.ers_held)
      begin
         allowed = is_held_ok(i_cmd_opcode) || (i_cmd_opcode == OPC_BUF_WR)
                   || (is_res(i_cmd_opcode) && can_resume)
                   || (is_prog(i_cmd_opcode) && i_cmd_block != st_r.ers_blk);
      end
      else
      begin
         allowed = !is_halt(i_cmd_opcode) && !is_res(i_cmd_opcode);
      end
   end

   assign o_cmd_accept     = i_cmd_valid && allowed;
   assign o_cmd_drop       = i_cmd_valid && !allowed;
   assign o_read_undefined = i_cmd_valid && allowed && is_read(i_cmd_opcode)
                             && ((st_r.prg_held && i_cmd_block == st_r.prg_blk)
                             || (st_r.ers_held && i_cmd_block == st_r.ers_blk));

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing
   logic cs_ok;
   logic do_halt;
   logic do_res;

   assign cs_ok   = i_cs_rise && i_cs_aligned;
   assign do_halt = cs_ok && st_r.pend == PEND_HALT && can_suspend;
   assign do_res  = cs_ok && st_r.pend == PEND_RES && can_resume;

   always_comb
   begin
      st_nxt           = st_r;
      st_nxt.halt_req  = 1'b0;
      st_nxt.res_req   = 1'b0;
      tmr_if.start     = 1'b0;
      tmr_if.count     = '0;
      if (o_cmd_accept && is_halt(i_cmd_opcode))
      begin
         st_nxt.pend = PEND_HALT;
      end
      else if (o_cmd_accept && is_res(i_cmd_opcode))
      begin
         st_nxt.pend = PEND_RES;
      end
      else if (o_cmd_accept)
      begin
         st_nxt.pend = PEND_NONE;
      end
      if (i_cs_rise)
      begin
         st_nxt.pend = PEND_NONE;
         case (st_r.pend)
            PEND_HALT:
            begin
               if (do_halt)
               begin
                  st_nxt.busy     = 1'b0;
                  st_nxt.paused   = 1'b1;
                  st_nxt.halt_req = 1'b1;
                  st_nxt.run      = KIND_NONE;
                  tmr_if.start    = 1'b1;
                  tmr_if.count    = TMR_W'(HALT_LAT_CYC);
                  if (st_r.run == KIND_PROG)
                  begin
                     st_nxt.prg_held = 1'b1;
                     st_nxt.prg_blk  = st_r.run_blk;
                  end
                  else
                  begin
                     st_nxt.ers_held = 1'b1;
                     st_nxt.ers_blk  = st_r.run_blk;
                  end
               end
            end
            PEND_RES:
            begin
               if (do_res)
               begin
                  st_nxt.busy    = 1'b1;
                  st_nxt.res_req = 1'b1;
                  tmr_if.start   = 1'b1;
                  tmr_if.count   = TMR_W'(CONT_LAT_CYC);
                  if (st_r.prg_held)
                  begin
                     st_nxt.prg_held  = 1'b0;
                     st_nxt.paused    = st_r.ers_held;
                     st_nxt.run       = KIND_PROG;
                     st_nxt.run_blk   = st_r.prg_blk;
                     st_nxt.res_erase = 1'b0;
                  end
                  else
                  begin
                     st_nxt.ers_held  = 1'b0;
                     st_nxt.paused    = 1'b0;
                     st_nxt.run       = KIND_ERASE;
                     st_nxt.run_blk   = st_r.ers_blk;
                     st_nxt.res_erase = 1'b1;
                  end
               end
            end
            default:
            begin
               st_nxt.pend = PEND_NONE;
            end
         endcase
      end
      // New operation admitted by the decoder; erase never starts while
      // a program is suspended, since admission refused it
      if (i_op_start && !st_r.busy)
      begin
         st_nxt.busy    = 1'b1;
         st_nxt.run     = i_op_kind;
         st_nxt.run_blk = i_op_block;
      end
      else if (i_op_done && st_r.busy)
      begin
         st_nxt.busy = 1'b0;
         st_nxt.run  = KIND_NONE;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         st_r <= '{busy: 1'b0, paused: 1'b0, prg_held: 1'b0, ers_held: 1'b0, run: KIND_NONE,
                   run_blk: BLK_RST, prg_blk: BLK_RST, ers_blk: BLK_RST,
                   pend: PEND_NONE, halt_req: 1'b0, res_req: 1'b0, res_erase: 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign o_suspend_req            = st_r.halt_req;
   assign o_resume_req             = st_r.res_req;
   assign o_resume_is_erase        = st_r.res_erase;
   assign o_latency_busy           = tmr_if.busy;
   assign o_ready_busy_flag        = st_r.busy;
   assign o_paused_op_flag         = st_r.paused;
   assign o_program_suspended_flag = st_r.prg_held;
   assign o_erase_suspended_flag   = st_r.ers_held;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   a_busy_sfdp_refused: assert property (
      i_cmd_valid && st_r.busy && i_cmd_opcode == OPC_SFDP |-> !o_cmd_accept)
      else $error("SFDP accepted while busy");
   a_pgm_udpd_refused: assert property (
      i_cmd_valid && st_r.prg_held && !st_r.busy && (i_cmd_opcode == OPC_UDPD
      || i_cmd_opcode == OPC_WRSR_I) |-> o_cmd_drop)
      else $error("Refused command passed in program suspension");
   a_ers_dpd_refused: assert property (
      i_cmd_valid && st_r.ers_held && !st_r.busy && (i_cmd_opcode == OPC_DPD
      || i_cmd_opcode == OPC_SR_LOCK) |-> o_cmd_drop)
      else $error("Refused command passed in erase suspension");
   a_ers_same_block: assert property (
      i_cmd_valid && st_r.ers_held && !st_r.prg_held && !st_r.busy && is_prog(i_cmd_opcode)
      |-> o_cmd_accept == (i_cmd_block != st_r.ers_blk))
      else $error("Program block check wrong in erase suspension");
   a_suspend_flags: assert property (
      do_halt |=> o_suspend_req && o_paused_op_flag && !o_ready_busy_flag
      && (o_program_suspended_flag || o_erase_suspended_flag) ##1 !o_suspend_req)
      else $error("Suspend did not update flags");
   a_fixed_no_halt: assert property (
      st_r.run == KIND_FIXED && i_cs_rise && !i_op_done
      |=> !o_suspend_req && o_ready_busy_flag)
      else $error("Non-suspendable operation suspended");
   a_misaligned_nop: assert property (
      i_cs_rise && !i_cs_aligned && !i_op_start |=> !o_suspend_req && !o_resume_req
      && $stable(o_program_suspended_flag) && $stable(o_erase_suspended_flag))
      else $error("Action on misaligned chip select");
   a_resume_flags: assert property (
      do_res && !st_r.prg_held |=> o_resume_req && o_ready_busy_flag && o_resume_is_erase
      && !o_erase_suspended_flag && !o_paused_op_flag)
      else $error("Erase resume flags wrong");
   a_resume_guard: assert property (
      do_res |=> (!(i_cmd_valid && is_halt(i_cmd_opcode)) || o_cmd_drop) [*8])
      else $error("Suspend accepted during resume latency");
   a_nested_order: assert property (
      do_res && st_r.prg_held && st_r.ers_held |=> !o_resume_is_erase && o_erase_suspended_flag
      && o_paused_op_flag && !o_program_suspended_flag)
      else $error("Nested resume restarted the erase first");

   c_suspend_prog: cover property (do_halt && st_r.run == KIND_PROG);
   c_suspend_erase: cover property (do_halt && st_r.run == KIND_ERASE);
   c_nested_resume: cover property (do_res && st_r.prg_held && st_r.ers_held);
   c_ers_program: cover property (o_cmd_accept && st_r.ers_held && is_prog(i_cmd_opcode));
endmodule : fsr_ctrl

// ===== bench/fsr_host_model.sv
// Host command source: framed opcodes with chip select rise
`timescale 1ns/1ps
module fsr_host_model
   import fsr_pkg::*;
(
   // Clock
   input  wire logic             i_core_clk,
   // Decoded command and chip select event
   output logic                  o_cmd_valid,
   output logic [7:0]            o_cmd_opcode,
   output logic [BLK_W-1:0]      o_cmd_block,
   output logic                  o_cs_rise,
   output logic                  o_cs_aligned,
   // Admission answer
   input  wire logic             i_cmd_accept,
   input  wire logic             i_cmd_drop,
   input  wire logic             i_read_undefined
);
   initial
   begin
      o_cmd_valid  = 1'b0;
      o_cmd_opcode = 8'hA5;
      o_cmd_block  = '0;
      o_cs_rise    = 1'b0;
      o_cs_aligned = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One opcode frame; released lines show the inverse value
   task automatic send(input logic [7:0] op, input logic [BLK_W-1:0] blk,
                       input logic al, output logic acc, output logic drp,
                       output logic und);
      @(negedge i_core_clk);
      o_cmd_valid  = 1'b1;
      o_cmd_opcode = op;
      o_cmd_block  = blk;
      #1;
      acc = i_cmd_accept;
      drp = i_cmd_drop;
      und = i_read_undefined;
      @(negedge i_core_clk);
      o_cmd_valid  = 1'b0;
      o_cmd_opcode = ~op;
      o_cmd_block  = ~blk;
      o_cs_rise    = 1'b1;
      o_cs_aligned = al;
      @(negedge i_core_clk);
      o_cs_rise    = 1'b0;
      o_cs_aligned = ~al;
   endtask : send
endmodule : fsr_host_model

// ===== bench/flash_suspend_resume_control_test.sv
// Testbench for the suspend/resume command admission control
`timescale 1ns/1ps
module flash_suspend_resume_control_test;
   import fsr_pkg::*;
   typedef logic [7:0] fsr_op_q_t[$];
   logic             i_core_clk, i_reset, cmd_valid, cs_rise, cs_aligned;
   logic [7:0]       cmd_opcode;
   logic [BLK_W-1:0] cmd_block, op_block;
   logic             op_start, op_done, accept, drop, rd_undef, halt_req, res_req;
   logic             res_erase, lat_busy, busy_f, paused_f, prog_f, erase_f, acc, drp, und;
   fsr_kind_t        op_kind;
   int               fail_count, n_compared;

   initial i_core_clk = 1'b0;
   always #25 i_core_clk = ~i_core_clk;

   fsr_host_model i_host (.i_core_clk(i_core_clk), .o_cmd_valid(cmd_valid),
      .o_cmd_opcode(cmd_opcode), .o_cmd_block(cmd_block), .o_cs_rise(cs_rise),
      .o_cs_aligned(cs_aligned), .i_cmd_accept(accept), .i_cmd_drop(drop),
      .i_read_undefined(rd_undef));

   fsr_ctrl i_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_cmd_valid(cmd_valid),
      .i_cmd_opcode(cmd_opcode), .i_cmd_block(cmd_block), .o_cmd_accept(accept),
      .o_cmd_drop(drop), .o_read_undefined(rd_undef), .i_cs_rise(cs_rise),
      .i_cs_aligned(cs_aligned), .i_op_start(op_start), .i_op_kind(op_kind),
      .i_op_block(op_block), .i_op_done(op_done), .o_suspend_req(halt_req),
      .o_resume_req(res_req), .o_resume_is_erase(res_erase), .o_latency_busy(lat_busy),
      .o_ready_busy_flag(busy_f), .o_paused_op_flag(paused_f),
      .o_program_suspended_flag(prog_f), .o_erase_suspended_flag(erase_f));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cmd(input logic [7:0] op, input logic [BLK_W-1:0] blk,
                      input logic al, input logic exp);
      i_host.send(op, blk, al, acc, drp, und);
      check($sformatf("accept %h", op), acc, exp);
      check($sformatf("drop %h", op), drp, !exp);
   endtask : cmd

   task automatic run_list(input fsr_op_q_t q, input logic exp);
      foreach (q[i])
         cmd(q[i], '0, 1'b1, exp);
   endtask : run_list

   task automatic flags(input logic b, input logic p, input logic s, input logic e);
      check("busy", busy_f, b);
      check("paused", paused_f, p);
      check("prog_held", prog_f, s);
      check("erase_held", erase_f, e);
   endtask : flags

   task automatic op(input fsr_kind_t k, input logic [BLK_W-1:0] blk, input logic fin);
      @(negedge i_core_clk);
      op_start = !fin;
      op_done  = fin;
      op_kind  = k;
      op_block = blk;
      @(negedge i_core_clk);
      op_start = 1'b0;
      op_done  = 1'b0;
      op_kind  = KIND_NONE;
      op_block = ~blk;
   endtask : op

   // Bounded wait for the latency window to close
   task automatic wait_lat;
      int n;
      n = 0;
      while (lat_busy !== 1'b0)
      begin
         @(negedge i_core_clk);
         n++;
         if (n > 500)
         begin
            check("lat_busy", lat_busy, 8'h00);
            end_sim();
         end
      end
   endtask : wait_lat
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      fail_count = 0;
      n_compared = 0;
      i_reset    = 1'b1;
      op_start   = 1'b0;
      op_done    = 1'b0;
      op_kind    = KIND_NONE;
      op_block   = '0;
      repeat (12) @(negedge i_core_clk);
      i_reset = 1'b0;
      cmd(8'h7A, '0, 1'b1, 1'b0);
      op(KIND_PROG, 4'h3, 1'b0);
      flags(1, 0, 0, 0);
      run_list({8'h05, 8'h35, 8'h15, 8'h65, 8'h25, 8'hF0, 8'h66, 8'h99, 8'h9F,
                8'h90, 8'h94, 8'hAB}, 1'b1);
      run_list({8'h5A, 8'h77, 8'hEF, 8'hB9, 8'h79, 8'h71, 8'h6F, 8'h03, 8'h06,
                8'h7A}, 1'b0);
      cmd(8'h75, '0, 1'b0, 1'b1);
      check("halt_req", halt_req, 0);
      flags(1, 0, 0, 0);
      cmd(8'h75, '0, 1'b1, 1'b1);
      check("halt_req", halt_req, 1);
      check("lat_busy", lat_busy, 1);
      flags(0, 1, 1, 0);
      run_list({8'h5A, 8'h77, 8'hEF, 8'h03, 8'hD4, 8'h06, 8'h04, 8'h50, 8'h3C,
                8'h3D, 8'h4B, 8'h25, 8'h0B, 8'h3B, 8'h6B, 8'hEB, 8'hE7}, 1'b1);
      run_list({8'h71, 8'h6F, 8'hB9, 8'h79, 8'h20, 8'h02, 8'h84, 8'h75}, 1'b0);
      wait_lat();
      cmd(8'hD0, '0, 1'b1, 1'b1);
      check("res_req", res_req, 1);
      check("res_erase", res_erase, 0);
      check("lat_busy", lat_busy, 1);
      flags(1, 0, 0, 0);
      cmd(8'h75, '0, 1'b1, 1'b0);
      flags(1, 0, 0, 0);
      wait_lat();
      op(KIND_NONE, '0, 1'b1);
      op(KIND_ERASE, 4'h5, 1'b0);
      cmd(8'hB0, '0, 1'b1, 1'b1);
      flags(0, 1, 0, 1);
      run_list({8'h5A, 8'h77, 8'hEF, 8'h84, 8'h0B}, 1'b1);
      run_list({8'hA2, 8'h32, 8'h88, 8'hAD, 8'hAF}, 1'b1);
      run_list({8'h6F, 8'hB9, 8'h71, 8'h79, 8'h20, 8'h60}, 1'b0);
      cmd(8'h02, 4'h5, 1'b1, 1'b0);
      cmd(8'h02, 4'h6, 1'b1, 1'b1);
      cmd(8'h03, 4'h5, 1'b1, 1'b1);
      check("rd_undef", und, 1);
      cmd(8'h03, 4'h6, 1'b1, 1'b1);
      check("rd_undef", und, 0);
      wait_lat();
      op(KIND_PROG, 4'h6, 1'b0);
      flags(1, 1, 0, 1);
      cmd(8'h75, '0, 1'b1, 1'b1);
      flags(0, 1, 1, 1);
      wait_lat();
      cmd(8'h7A, '0, 1'b1, 1'b1);
      check("res_erase", res_erase, 0);
      flags(1, 1, 0, 1);
      cmd(8'hD0, '0, 1'b1, 1'b0);
      wait_lat();
      op(KIND_NONE, '0, 1'b1);
      cmd(8'hD0, '0, 1'b1, 1'b1);
      check("res_erase", res_erase, 1);
      flags(1, 0, 0, 0);
      wait_lat();
      op(KIND_NONE, '0, 1'b1);
      op(KIND_FIXED, 4'h0, 1'b0);
      cmd(8'h75, '0, 1'b1, 1'b0);
      check("halt_req", halt_req, 0);
      flags(1, 0, 0, 0);
      // Mid-run reset clears every flag
      @(negedge i_core_clk);
      i_reset = 1'b1;
      @(negedge i_core_clk);
      i_reset = 1'b0;
      flags(0, 0, 0, 0);
      check("lat_busy", lat_busy, 0);
      cmd(8'hD0, '0, 1'b1, 1'b0);
      end_sim();
   end
endmodule : flash_suspend_resume_control_test
